// ### include/ccu_pkg.sv
/*
 * ccu_pkg: register offsets, field layouts, reset values, mode codes and
 * carrier types of the capture/compare unit.
 * assumes: included before the unit; 8-bit register port with 3-bit address.
 */
package ccu_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int ADDR_W  = 3;
    localparam int DATA_W  = 8;
    localparam int COUNT_W = 16;
    localparam int PRE_W   = 4;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 3'h0; // channel_control_register
    localparam logic [ADDR_W-1:0] OFF_CCR_LO = 3'h1; // capture_compare_low_byte
    localparam logic [ADDR_W-1:0] OFF_CCR_HI = 3'h2; // capture_compare_high_byte
    localparam logic [ADDR_W-1:0] OFF_TSEL   = 3'h3; // pwm_timer_select
    localparam logic [ADDR_W-1:0] OFF_FLAG   = 3'h4; // channel_interrupt_flag
    localparam logic [ADDR_W-1:0] OFF_PORT   = 3'h5; // port latch, direction, compare latch

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int FLAG_BIT    = 0;
    localparam int PORT_BIT    = 0;
    localparam int DIR_BIT     = 1;
    localparam int CMPL_BIT    = 2;
    localparam int MODE_W      = 4;
    localparam int TSEL_U1_LSB = 0; // unit1_timer_field
    localparam int TSEL_U2_LSB = 2; // unit2_timer_field
    localparam int TSEL_P3_LSB = 4; // pwm_ch3_timer_field
    localparam int TSEL_P4_LSB = 6; // pwm_ch4_timer_field
    localparam logic [DATA_W-1:0]  RST_CTRL = 8'h00;
    localparam logic [DATA_W-1:0]  RST_TSEL = 8'h00;
    localparam logic [COUNT_W-1:0] RST_CCR  = 16'h0000;
    localparam logic               RST_DIR  = 1'h1; // pin is an input after reset
    localparam logic [PRE_W-1:0]   PRE_MAX4  = 4'h3;
    localparam logic [PRE_W-1:0]   PRE_MAX16 = 4'hf;

    // ------------------------------------------------------------------
    // channel mode codes and time base codes
    // ------------------------------------------------------------------
    localparam logic [MODE_W-1:0] M_OFF    = 4'h0;
    localparam logic [MODE_W-1:0] M_TOGGLE = 4'h2;
    localparam logic [MODE_W-1:0] M_CAP_F  = 4'h4;
    localparam logic [MODE_W-1:0] M_CAP_R  = 4'h5;
    localparam logic [MODE_W-1:0] M_CAP_4  = 4'h6;
    localparam logic [MODE_W-1:0] M_CAP_16 = 4'h7;
    localparam logic [MODE_W-1:0] M_SET    = 4'h8;
    localparam logic [MODE_W-1:0] M_CLR    = 4'h9;
    localparam logic [MODE_W-1:0] M_SWI    = 4'ha;
    localparam logic [MODE_W-1:0] M_TRIG   = 4'hb;
    localparam logic [1:0]        PWM_TOP  = 2'h3; // modes 11xx are pwm

    typedef enum logic [1:0] {
        TB_A = 2'h0,
        TB_B = 2'h1,
        TB_C = 2'h2,
        TB_R = 2'h3
    } ccu_tbase_t;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
        logic              re;
    } ccu_bus_req_t;

    typedef struct packed {
        logic a;
        logic b;
        logic c;
    } ccu_ptick_t;

endpackage

// ### logic/ccu_unit.sv
/*
 * ccu_unit: one capture/compare channel with its pin logic, and the pwm
 * time base selection register for the four pwm channels.
 * assumes: the sixteen_bit_timer count arrives on clk; period timer match
 * pulses are one-cycle pulses on clk; the channel pin comes from outside.
 */
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// [R1] a qualifying pin event copies the whole 16-bit timer count into the pair
// [R2] mode picks capture on falling, rising, every 4th or 16th rising edge
// [R3] each capture sets the channel flag; only software clears it
// [R4] a new capture overwrites an unread captured value
// [R5] with the pin driven, a port write changing its level can capture
// [R6] prescaler counter clears when off, outside capture mode, and on reset
// [R7] switching between capture prescales keeps the counter; may false capture
// [R8] software should write zero to control before a new prescale
// [R9] software keeps interrupt enable low across mode change, then clears flag
// [R10] timer should run in timer or synchronized counter mode
// [R11] timer should not run from the system oscillator in these modes
// [R12] sleep blocks only compare matches here; capture runs in sleep on an external clock
// [R13] compare match toggles, sets, clears pin, triggers conversion, or interrupts
// [R14] every compare match sets the channel flag with its action
// [R15] writing zero to control forces compare latch low, port latch untouched
// [R16] software interrupt mode never drives the pin on a match
// [R17] software makes the pin an input to capture, an output to compare
// [R18] timer selection register holds four readable, writable 2-bit fields
// [R19] field codes 00, 01, 10 pick period timer a, b, c
// [R20] unit fields act only while that unit is in pwm mode
// [R21] trigger mode match resets the timer, starts enabled converter, no pin
// [R22] reserved selection code behaves like code 00
module ccu_unit
    import ccu_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // register port
    input  wire ccu_bus_req_t       bus_req,
    output logic [DATA_W-1:0]       bus_rdata,
    // timer and system
    input  wire logic [COUNT_W-1:0] timer_count,
    input  wire logic               sleep,
    input  wire logic               conv_enabled,
    output logic                    timer_reset,
    output logic                    conv_start,
    // channel pin
    input  wire logic               pin_in,
    output logic                    pin_out,
    output logic                    pin_oe_n,
    // pwm time bases
    input  wire ccu_ptick_t         period_tick,
    input  wire logic               unit2_pwm_mode,
    output logic [3:0]              pwm_tick
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic sel_tick(input logic [1:0] code, input ccu_ptick_t t);
        case (ccu_tbase_t'(code))
            TB_B:    sel_tick = t.b;
            TB_C:    sel_tick = t.c;
            default: sel_tick = t.a; // R22
        endcase
    endfunction
    function automatic logic is_cap(input logic [MODE_W-1:0] m);
        is_cap = (m == M_CAP_F) || (m == M_CAP_R) || (m == M_CAP_4) || (m == M_CAP_16);
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [MODE_W-1:0]  mode_q;
    logic [DATA_W-1:0]  tsel_q;
    logic [COUNT_W-1:0] ccr_q;
    logic               flag_q;
    logic               port_q;
    logic               dir_q;
    logic               cmpl_q;
    logic               pin_out_q;
    logic [PRE_W-1:0]   pre_q;
    logic               sync1_q;
    logic               sync2_q;
    logic               sync3_q;
    logic               pin_lvl_q;
    logic               src_q;
    logic               match_q;
    logic [DATA_W-1:0]  rd_q;
    logic src;
    logic rise;
    logic fall;
    logic cap_mode;
    logic cmp_mode;
    logic cap_evt;
    logic match;
    logic match_evt;
    logic wr_ctrl;
    logic wr_lo;
    logic wr_hi;
    logic wr_flag;
    logic wr_port;
    logic pwm_mode;

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    assign wr_ctrl = bus_req.we && (bus_req.addr == OFF_CTRL);
    assign wr_lo   = bus_req.we && (bus_req.addr == OFF_CCR_LO);
    assign wr_hi   = bus_req.we && (bus_req.addr == OFF_CCR_HI);
    assign wr_flag = bus_req.we && (bus_req.addr == OFF_FLAG);
    assign wr_port = bus_req.we && (bus_req.addr == OFF_PORT);
    // control register: mode field
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= RST_CTRL[MODE_W-1:0];
        end else if (wr_ctrl) begin
            mode_q <= bus_req.wdata[MODE_W-1:0];
        end
    end
    // timer selection register, all fields plain read/write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tsel_q <= RST_TSEL;
        end else if (bus_req.we && (bus_req.addr == OFF_TSEL)) begin
            tsel_q <= bus_req.wdata; // R18
        end
    end
    // port data latch and direction bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_q <= 1'h0;
            dir_q  <= RST_DIR;
        end else if (wr_port) begin
            port_q <= bus_req.wdata[PORT_BIT]; // R15
            dir_q  <= bus_req.wdata[DIR_BIT];
        end
    end
    // read data, valid the cycle after the strobe only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_q <= '0;
        end else if (bus_req.re) begin
            case (bus_req.addr)
                OFF_CTRL:   rd_q <= {{(DATA_W-MODE_W){1'b0}}, mode_q};
                OFF_CCR_LO: rd_q <= ccr_q[DATA_W-1:0];
                OFF_CCR_HI: rd_q <= ccr_q[COUNT_W-1:DATA_W];
                OFF_TSEL:   rd_q <= tsel_q; // R18
                OFF_FLAG:   rd_q <= {{(DATA_W-1){1'b0}}, flag_q};
                OFF_PORT:   rd_q <= {{(DATA_W-3){1'b0}}, cmpl_q, dir_q, port_q};
                default:    rd_q <= '0;
            endcase
        end else begin
            rd_q <= '0;
        end
    end
    assign bus_rdata = rd_q;

    // ------------------------------------------------------------------
    // pin input synchroniser and edge detect
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q   <= 1'h0;
            sync2_q   <= 1'h0;
            sync3_q   <= 1'h0;
            pin_lvl_q <= 1'h0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q == sync3_q) begin
                pin_lvl_q <= sync3_q;
            end
        end
    end

    // a driven pin sees its own output, so port writes can capture
    assign src = dir_q ? pin_lvl_q : pin_out_q; // R5
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_q <= 1'h0;
        end else begin
            src_q <= src;
        end
    end
    assign rise = src && !src_q;
    assign fall = !src && src_q;
    // ------------------------------------------------------------------
    // capture
    // ------------------------------------------------------------------
    assign cap_mode = is_cap(mode_q);
    // prescale counter on rising edges; cleared on reset and outside capture modes only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_q <= '0; // R6
        end else if (!cap_mode) begin
            pre_q <= '0; // R6
        end else if (rise) begin
            pre_q <= pre_q + 1'b1; // R7
        end
    end
    // event selection; capture keeps going in sleep
    always_comb begin
        case (mode_q)
            M_CAP_F:  cap_evt = fall; // R2
            M_CAP_R:  cap_evt = rise; // R2
            M_CAP_4:  cap_evt = rise && (pre_q[1:0] == PRE_MAX4[1:0]); // R2
            M_CAP_16: cap_evt = rise && (pre_q == PRE_MAX16); // R2
            default:  cap_evt = 1'b0;
        endcase
    end
    // capture/compare pair: capture beats a software write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ccr_q <= RST_CCR;
        end else if (cap_evt) begin
            ccr_q <= timer_count; // R1 R4 R12
        end else begin
            if (wr_lo) begin
                ccr_q[DATA_W-1:0] <= bus_req.wdata;
            end
            if (wr_hi) begin
                ccr_q[COUNT_W-1:DATA_W] <= bus_req.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // compare
    // ------------------------------------------------------------------
    assign cmp_mode  = (mode_q == M_TOGGLE) || (mode_q == M_SET) || (mode_q == M_CLR)
                    || (mode_q == M_SWI) || (mode_q == M_TRIG);
    assign match     = cmp_mode && !sleep && (ccr_q == timer_count); // R13
    assign match_evt = match && !match_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            match_q <= 1'h0;
        end else begin
            match_q <= match;
        end
    end
    // compare output latch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmpl_q <= 1'h0;
        end else if (wr_ctrl && (bus_req.wdata == RST_CTRL)) begin
            cmpl_q <= 1'h0; // R15
        end else if (match_evt) begin
            case (mode_q)
                M_TOGGLE: cmpl_q <= !cmpl_q; // R13
                M_SET:    cmpl_q <= 1'h1; // R13
                M_CLR:    cmpl_q <= 1'h0; // R13
                default:  cmpl_q <= cmpl_q; // R16 R21
            endcase
        end
    end
    // conversion trigger and timer reset pulses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_reset <= 1'h0;
            conv_start  <= 1'h0;
        end else begin
            timer_reset <= match_evt && (mode_q == M_TRIG); // R21
            conv_start  <= match_evt && (mode_q == M_TRIG) && conv_enabled; // R21
        end
    end
    // pin drive: only toggle, set and clear modes hand the pin to the latch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out_q <= 1'h0;
        end else if ((mode_q == M_TOGGLE) || (mode_q == M_SET) || (mode_q == M_CLR)) begin
            pin_out_q <= cmpl_q; // R13
        end else begin
            pin_out_q <= port_q; // R16 R21
        end
    end
    assign pin_out  = pin_out_q;
    assign pin_oe_n = dir_q;
    // ------------------------------------------------------------------
    // channel interrupt flag: hardware set wins over software clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'h0;
        end else if (cap_evt || match_evt) begin
            flag_q <= 1'h1; // R3 R14
        end else if (wr_flag) begin
            flag_q <= bus_req.wdata[FLAG_BIT]; // R3
        end
    end
    // ------------------------------------------------------------------
    // pwm time base selection
    // ------------------------------------------------------------------
    assign pwm_mode = (mode_q[MODE_W-1:MODE_W-2] == PWM_TOP);
    always_comb begin
        pwm_tick[0] = pwm_mode && sel_tick(tsel_q[TSEL_U1_LSB +: 2], period_tick); // R19 R20
        pwm_tick[1] = unit2_pwm_mode && sel_tick(tsel_q[TSEL_U2_LSB +: 2], period_tick); // R20
        pwm_tick[2] = sel_tick(tsel_q[TSEL_P3_LSB +: 2], period_tick); // R19
        pwm_tick[3] = sel_tick(tsel_q[TSEL_P4_LSB +: 2], period_tick); // R19
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_cap;
        cap_evt;
    endsequence
    sequence s_stored;
        ##1 (ccr_q == $past(timer_count)) && flag_q;
    endsequence

    AST_CAPTURE_STORES: assert property (@(posedge clk) disable iff (rst) // R1
        s_cap |-> s_stored) else $error("capture did not store count and flag");
    AST_RISE_ONLY_CAP: assert property (@(posedge clk) disable iff (rst) // R2
        (mode_q == M_CAP_R) && !rise |-> !cap_evt) else $error("capture without rising edge");
    AST_FLAG_HOLDS: assert property (@(posedge clk) disable iff (rst) // R3
        flag_q && !wr_flag |=> flag_q) else $error("flag cleared by hardware");
    AST_PRE_CLEAR: assert property (@(posedge clk) disable iff (rst) // R6
        !cap_mode |=> (pre_q == '0) || cap_mode) else $error("prescaler not cleared");
    AST_PRE_KEEP: assert property (@(posedge clk) disable iff (rst) // R7
        cap_mode && wr_ctrl && is_cap(bus_req.wdata[MODE_W-1:0]) && !rise
        |=> pre_q == $past(pre_q)) else $error("prescaler lost on prescale change");
    AST_MATCH_FLAG: assert property (@(posedge clk) disable iff (rst) // R14
        match_evt |=> flag_q) else $error("compare match without flag");
    AST_ZERO_CLEARS: assert property (@(posedge clk) disable iff (rst) // R15
        wr_ctrl && (bus_req.wdata == RST_CTRL) |=> !cmpl_q && (port_q == $past(port_q)))
        else $error("zero control did not clear compare latch");
    AST_SWI_NO_DRIVE: assert property (@(posedge clk) disable iff (rst) // R16
        (mode_q == M_SWI) |=> pin_out_q == $past(port_q)) else $error("pin driven in swi");
    AST_TRIG_PULSE: assert property (@(posedge clk) disable iff (rst) // R21
        match_evt && (mode_q == M_TRIG) |=> timer_reset && (conv_start == $past(conv_enabled)))
        else $error("trigger mode did not reset timer");
    AST_RESERVED_A: assert property (@(posedge clk) disable iff (rst) // R22
        (tsel_q[TSEL_P3_LSB +: 2] == TB_R) |-> pwm_tick[2] == period_tick.a)
        else $error("reserved code not on timer a");
endmodule

// ### tb/ccu_pin_model.sv
/*
 * ccu_pin_model: the outside source or load on the channel pin.
 * assumes: the bench calls pulse(); the unit drives the pin while pin_oe_n is low.
 */
`timescale 1ns/1ps

module ccu_pin_model (
    // clock
    input  wire logic clk,
    // pin side of the unit
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    output logic      pin_in
);
    logic src_q = 1'b0;

    // wire level: the unit's drive wins while enabled, else the outside source
    assign pin_in = pin_oe_n ? src_q : pin_out;

    // whole pulses, each level held w cycles so the pin filter keeps every edge
    task automatic pulse(input int n, input int w);
        repeat (n) begin
            @(posedge clk);
            src_q <= 1'b1;
            repeat (w) @(posedge clk);
            src_q <= 1'b0;
            repeat (w) @(posedge clk);
        end
    endtask
endmodule

// ### tb/testbench.sv
/*
 * testbench: table driven checks of the capture/compare unit, then reset
 * and the awkward cases by hand.
 * assumes: ccu_pkg compiled first; the pin model stands on the channel pin.
 */
`timescale 1ns/1ps

module testbench;
    import ccu_pkg::*;

    // ------------------------------------------------------------------
    // tables
    // ------------------------------------------------------------------
    // capture rows: mode, rising edges, {sleep, flag}
    localparam logic [15:0] CAP [9] = '{16'h5011, 16'h4011, 16'h6020, 16'h6020,
        16'h6041, 16'h70f0, 16'h7101, 16'h5013, 16'h2010};
    // compare rows: mode, {sleep, conv, flag, latch}, {reset, start, pin, pin checked}
    localparam logic [11:0] CMP [8] = '{12'h833, 12'ha30, 12'h221, 12'h233,
        12'h921, 12'h881, 12'hb6c, 12'hb28};
    // time base rows: select, tick, unit two pwm, mode, expected ticks
    localparam logic [23:0] TSR [8] = '{24'he441c9, 24'he421c2, 24'he411c4, 24'he420c0,
        24'he44108, 24'h1b41c9, 24'h1b11c2, 24'h1b21c4};
    // register contents after reset, addresses 0 to 7
    localparam logic [7:0]  RST_EXP [8] = '{RST_CTRL, 8'h00, 8'h00, RST_TSEL,
        8'h00, 8'h02, 8'h00, 8'h00};

    logic               clk         = 1'b0;
    logic               rst         = 1'b1;
    ccu_bus_req_t       bus_req     = '0;
    logic [DATA_W-1:0]  bus_rdata;
    logic [COUNT_W-1:0] tval        = '0;
    logic               sleep       = 1'b0;
    logic               conv_en     = 1'b0;
    logic               timer_reset;
    logic               conv_start;
    logic               pin_in;
    logic               pin_out;
    logic               pin_oe_n;
    ccu_ptick_t         period_tick = '0;
    logic               u2_pwm      = 1'b0;
    logic [3:0]         pwm_tick;
    logic               run         = 1'b0;
    logic [COUNT_W-1:0] exp_ccr     = '0;
    int                 failures    = 0;
    int                 num_checks  = 0;
    int                 n_rst       = 0;
    int                 n_conv      = 0;
    int                 cyc         = 0;

    always #5 clk = ~clk;

    ccu_unit u_dut (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .timer_count(tval), .sleep(sleep), .conv_enabled(conv_en),
        .timer_reset(timer_reset), .conv_start(conv_start), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .period_tick(period_tick),
        .unit2_pwm_mode(u2_pwm), .pwm_tick(pwm_tick));

    ccu_pin_model u_pin (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));

    // timer on clk like the instruction clock, pulse counters and the hang limit
    always @(posedge clk) begin
        if (run)
            tval <= timer_reset ? '0 : tval + 16'h0001;
        if (timer_reset)
            n_rst++;
        if (conv_start)
            n_conv++;
        cyc++;
        if (cyc == 20000) begin
            failures++;
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        // sample mid-cycle where the data has settled, return on a rising edge
        @(negedge clk);
        chk({8'h00, bus_rdata}, {8'h00, e});
        @(posedge clk);
    endtask

    task automatic rdccr(input logic [15:0] e);
        rd(OFF_CCR_LO, e[7:0]);
        rd(OFF_CCR_HI, e[15:8]);
    endtask

    // timer from zero past the compare value 16'h0040, then stopped
    task automatic run_match();
        tval <= '0;
        run <= 1'b1;
        repeat (80) @(posedge clk);
        run <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // time base selection rows
        foreach (TSR[i]) begin
            wr(OFF_TSEL, TSR[i][23:16]);
            rd(OFF_TSEL, TSR[i][23:16]);
            wr(OFF_CTRL, {4'h0, TSR[i][7:4]});
            u2_pwm <= TSR[i][8];
            @(posedge clk);
            period_tick <= TSR[i][14:12];
            #1 chk({12'h000, pwm_tick}, {12'h000, TSR[i][3:0]});
            @(posedge clk);
            period_tick <= '0;
        end
        // capture rows, channel off between rows
        foreach (CAP[i]) begin
            wr(OFF_CTRL, 8'h00);
            tval <= 16'h1000 + 16'(i) * 16'h0111;
            sleep <= CAP[i][1];
            wr(OFF_CTRL, {4'h0, CAP[i][15:12]});
            wr(OFF_FLAG, 8'h00);
            u_pin.pulse(int'(CAP[i][11:4]), 6);
            if (CAP[i][0])
                exp_ccr = tval;
            rd(OFF_FLAG, {7'h00, CAP[i][0]});
            rdccr(exp_ccr);
        end
        sleep <= 1'b0;
        // compare rows with the pin made an output
        wr(OFF_PORT, 8'h00);
        tval <= 16'h0050;
        wr(OFF_CCR_LO, 8'h40);
        chk({15'h0000, pin_oe_n}, 16'h0000);
        wr(OFF_CCR_HI, 8'h00);
        foreach (CMP[i]) begin
            wr(OFF_FLAG, 8'h00);
            sleep <= CMP[i][7];
            conv_en <= CMP[i][6];
            wr(OFF_CTRL, {4'h0, CMP[i][11:8]});
            n_rst = 0;
            n_conv = 0;
            run_match();
            rd(OFF_FLAG, {7'h00, CMP[i][5]});
            rd(OFF_PORT, {5'h00, CMP[i][4], 2'h0});
            chk(16'(n_rst), {15'h0000, CMP[i][3]});
            chk(16'(n_conv), {15'h0000, CMP[i][2]});
            if (CMP[i][0])
                chk({15'h0000, pin_out}, {15'h0000, CMP[i][1]});
        end
        sleep <= 1'b0;
        // second reset in mid-run, then every address, one unmapped write
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk({14'h0000, pin_out, pin_oe_n}, 16'h0001);
        wr(3'h6, 8'hff);
        for (int a = 0; a < 8; a++)
            rd(3'(a), RST_EXP[a]);
        // unread capture overwritten; flag kept until software clears it
        tval <= 16'h1111;
        wr(OFF_CTRL, {4'h0, M_CAP_R});
        wr(OFF_FLAG, 8'h00);
        u_pin.pulse(1, 4);
        tval <= 16'h2222;
        u_pin.pulse(1, 4);
        rdccr(16'h2222);
        repeat (20) @(posedge clk);
        rd(OFF_FLAG, 8'h01);
        wr(OFF_FLAG, 8'h00);
        rd(OFF_FLAG, 8'h00);
        // prescale switch keeps the edge count: 16th edge overall captures
        wr(OFF_CTRL, 8'h00);
        wr(OFF_CTRL, {4'h0, M_CAP_4});
        u_pin.pulse(2, 6);
        wr(OFF_CTRL, {4'h0, M_CAP_16});
        wr(OFF_FLAG, 8'h00);
        u_pin.pulse(13, 6);
        rd(OFF_FLAG, 8'h00);
        u_pin.pulse(1, 6);
        rd(OFF_FLAG, 8'h01);
        // control zero clears the compare latch only
        tval <= 16'h0050;
        wr(OFF_CCR_LO, 8'h40);
        wr(OFF_CCR_HI, 8'h00);
        wr(OFF_PORT, 8'h00);
        wr(OFF_CTRL, {4'h0, M_SET});
        run_match();
        wr(OFF_PORT, 8'h05);
        rd(OFF_PORT, 8'h05);
        wr(OFF_CTRL, 8'h00);
        rd(OFF_PORT, 8'h01);
        // port writes on a driven pin make a capture
        tval <= 16'hbeef;
        wr(OFF_CTRL, {4'h0, M_CAP_R});
        wr(OFF_PORT, 8'h00);
        repeat (8) @(posedge clk);
        wr(OFF_FLAG, 8'h00);
        wr(OFF_PORT, 8'h01);
        repeat (8) @(posedge clk);
        rd(OFF_FLAG, 8'h01);
        rdccr(16'hbeef);
        complete_run();
    end
endmodule
